// file: core/smap_pkg.sv
// Shared constants and state codes of the synchronous modem adapter
package smap_pkg;

  // ==========================================================
  // Character framing
  localparam logic [7:0] SYNC_CHAR = 8'h16;
  localparam logic [7:0] PAR_SUB_CHAR = 8'h80;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] SYNC_CHAR_BITS = 4'h8;
  localparam logic [3:0] SS_CHAR_BITS = 4'ha;
  localparam logic [3:0] ONE_BIT = 4'h1;
  localparam logic MARK = 1'b1;
  localparam logic START_BIT = 1'b0;

  // ==========================================================
  // Status and interrupt bit positions on the adapter data bus
  localparam int STAT_W = 7;
  localparam int ST_READY = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_RATE = 4;
  localparam int ST_IDLE = 5;
  localparam int IC_PARITY = 2;
  localparam int IC_EOREC = 3;
  localparam int IC_RATE = 4;
  localparam int IC_ERR = 5;
  localparam int IC_NOCAR = 6;

  // ==========================================================
  // State counters
  typedef enum logic [2:0] {
    RX_OFF = 3'h0,
    RX_HUNT = 3'h1,
    RX_SYNC2 = 3'h2,
    RX_CHAR = 3'h3,
    RX_STOP = 3'h4,
    RX_RATE = 3'h5
  } smap_rx_state_t;

  typedef enum logic [2:0] {
    TX_OFF = 3'h0,
    TX_RTS = 3'h1,
    TX_REQ = 3'h2,
    TX_SEND = 3'h3,
    TX_FILL = 3'h4
  } smap_tx_state_t;

endpackage : smap_pkg

// file: core/smap_link_if.sv
// Signals between a link-clock end and the adapter core
`timescale 1ns/1ps
`default_nettype none
interface smap_link_if;
  logic dat;
  logic tog;
  logic out;
  modport link (output dat, output tog, input out);
  modport core (input dat, input tog, output out);
endinterface : smap_link_if
`default_nettype wire

// file: core/smap_rx_link.sv
// Receive link end: samples modem data on the modem receive clock
`timescale 1ns/1ps
`default_nettype none
module smap_rx_link
  import smap_pkg::*;
(
  // Link clock and reset
  input wire logic rx_serial_clock_i,
  input wire logic rst_i,
  // Modem data
  input wire logic rxd_i,
  // Toward the core
  smap_link_if.link lk
);

  // ==========================================================
  // State
  typedef struct packed {
    logic dat;
    logic tog;
  } smap_rxl_t;

  smap_rxl_t q;
  smap_rxl_t d;

  // Each bit is announced by a toggle; the bit is held a whole bit time,
  // which at modem rates is far longer than the core's synchroniser
  always_comb begin
    d = q;
    d.dat = rxd_i;
    d.tog = ~q.tog;
  end

  always_ff @(posedge rx_serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lk.dat = q.dat;
  assign lk.tog = q.tog;

endmodule : smap_rx_link
`default_nettype wire

// file: core/smap_tx_link.sv
// Transmit link end: retimes the core's line bit onto the modem clock
`timescale 1ns/1ps
`default_nettype none
module smap_tx_link
  import smap_pkg::*;
(
  // Link clock and reset
  input wire logic tx_serial_clock_i,
  input wire logic rst_i,
  // Modem data
  output logic txd_o,
  // Toward the core
  smap_link_if.link lk
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] sy;
    logic txd;
    logic tog;
  } smap_txl_t;

  smap_txl_t q;
  smap_txl_t d;

  // Two flops bring the core bit over; a third flop then drives it onto the line
  always_comb begin
    d = q;
    d.sy = {q.sy[0], lk.out};
    d.txd = q.sy[1];
    d.tog = ~q.tog;
  end

  always_ff @(posedge tx_serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign txd_o = q.txd;
  assign lk.dat = q.txd;
  assign lk.tog = q.tog;

endmodule : smap_tx_link
`default_nettype wire

// file: core/smap_adapter.sv
// Synchronous modem adapter: receive and transmit core with its link ends
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Synchronous link, full or half duplex, modem clocks, up to 9600 baud.
// - Sync mode: 8-bit characters, aligned on two consecutive sync characters.
// - Start-stop mode takes start bit, seven data, parity and stop bit.
// - Parity checked per character; code transparent apart from sync pattern.
// - Receive status on bits 0,1,2,4; transmit status on bits 0,1,5.
// - Parity error flag set when a character completes with bad parity.
// - Start transmit order sets transmit busy directly.
// - After sync or start bit, assemble characters, strip framing and parity.
// - Bad parity delivers the byte with top bit set, or 80 hex, by option.
// - Receiver has no check order; stop data order ends reception.
// - Interrupts on carrier loss, parity, rate error; bit 6 flags carrier.
// - With no character waiting, a pending interrupt raises the request line.
// - A character is handed over between request and acknowledge.
// - Character flag high at a receive clock sets overrun and the rate state.
// - Error summary bit 5 set on parity error or overrun.
// - Transmit side decodes start, stop, idle orders only; no check register.
// - Odd or even parity generated for each transmitted character.
// - Start-stop mode frames each transmitted character with start and stop.
// - Idle order drives the line steadily with ones or zeros by option.
// - Idle fill sets status bit 5, end-of-record bit 3, advances state.
// - Stop order waits one character time, then sets end-of-record.
// - Stop reset with transmit enable clears state, request and busy.
// - Start raises request-to-send; clear-to-send moves on to data requests.
// - Transmit clock before next data sets interrupt bits 3 and 5.
module smap_adapter
  import smap_pkg::*;
(
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rx_serial_clock_i,
  input wire logic tx_serial_clock_i,
  // Modem
  input wire logic rxd_i,
  input wire logic carrier_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  output logic rts_o,
  output logic txd_o,
  // Options
  input wire logic sync_mode_i,
  input wire logic parity_en_i,
  input wire logic parity_odd_i,
  input wire logic par_sub80_i,
  input wire logic idle_ones_i,
  // Orders
  input wire logic stop_reset_i,
  input wire logic tx_enable_i,
  input wire logic tx_start_order_i,
  input wire logic tx_stop_order_i,
  input wire logic tx_idle_order_i,
  input wire logic rx_start_order_i,
  input wire logic rx_stop_order_i,
  // Receive side of the multiplexer
  output logic rx_request_o,
  input wire logic rx_acknowledge_i,
  output logic [7:0] rx_data_o,
  output logic [STAT_W-1:0] rx_status_o,
  output logic [STAT_W-1:0] rx_interrupt_condition_bits_o,
  // Transmit side of the multiplexer
  output logic tx_request_o,
  input wire logic tx_ack_i,
  input wire logic [7:0] tx_data_i,
  output logic [STAT_W-1:0] tx_status_o,
  output logic [STAT_W-1:0] tx_interrupt_condition_bits_o
);

  // ==========================================================
  // Link ends
  smap_link_if rx_lk ();
  smap_link_if tx_lk ();

  smap_rx_link u_rx_link (
    .rx_serial_clock_i (rx_serial_clock_i),
    .rst_i (rst_i),
    .rxd_i (rxd_i),
    .lk (rx_lk.link)
  );

  smap_tx_link u_tx_link (
    .tx_serial_clock_i (tx_serial_clock_i),
    .rst_i (rst_i),
    .txd_o (txd_o),
    .lk (tx_lk.link)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] car_s;
    logic [2:0] cts_s;
    logic [2:0] dsr_s;
    logic [2:0] rtg_s;
    logic [2:0] ttg_s;
    logic car;
    logic cts;
    logic dsr;
    logic rtg;
    logic ttg;
    smap_rx_state_t rst;
    logic [7:0] rsh;
    logic [3:0] rcnt;
    logic rflag;
    logic [7:0] rdat;
    logic rbusy;
    logic rpfe;
    logic rovr;
    logic [STAT_W-1:0] rint;
    logic rreq;
    logic [STAT_W-1:0] rstat;
    smap_tx_state_t tst;
    logic [9:0] tsh;
    logic [3:0] tcnt;
    logic [3:0] tdly;
    logic tbusy;
    logic treq;
    logic tidle;
    logic tstopd;
    logic tfirst;
    logic tbit;
    logic rts;
    logic [STAT_W-1:0] tint;
    logic treqo;
    logic [STAT_W-1:0] tstat;
  } smap_core_t;

  smap_core_t q;
  smap_core_t d;

  // A change counts once the second and third flops agree
  function automatic logic smap_flt(input logic [2:0] s, input logic f);
    smap_flt = (s[1] == s[2]) ? s[2] : f;
  endfunction : smap_flt

  // ==========================================================
  // Decoded events
  logic rx_ev;
  logic tx_ev;
  logic tx_rst;
  logic rx_ord;
  logic rx_done;
  logic rx_ovr;
  logic rx_perr;
  logic rx_use_par;
  logic [7:0] rx_char;
  logic [7:0] rx_byte;
  logic [7:0] tx_char;

  assign rx_ev = smap_flt(q.rtg_s, q.rtg) != q.rtg;
  assign tx_ev = smap_flt(q.ttg_s, q.ttg) != q.ttg;
  assign tx_rst = stop_reset_i & tx_enable_i;
  assign rx_ord = rx_start_order_i | rx_stop_order_i;
  assign rx_char = {rx_lk.dat, q.rsh[7:1]};
  assign rx_use_par = parity_en_i | ~sync_mode_i;
  assign rx_perr = rx_use_par & ((^rx_char) != parity_odd_i);
  assign rx_done = rx_ev & ~rx_ord & ~q.rflag & (q.rst == RX_CHAR) &
                   (q.rcnt == BIT_LAST);
  assign rx_ovr = rx_ev & ~rx_ord & q.rflag &
                  ((q.rst == RX_CHAR) | (q.rst == RX_STOP));
  // Parity and framing never reach the multiplexer
  assign rx_byte = rx_perr ? (par_sub80_i ? PAR_SUB_CHAR
                                          : {1'b1, rx_char[6:0]})
                 : (rx_use_par ? {1'b0, rx_char[6:0]} : rx_char);
  assign tx_char = (sync_mode_i & ~parity_en_i) ? tx_data_i
                 : {(^tx_data_i[6:0]) ^ parity_odd_i, tx_data_i[6:0]};
  assign rx_lk.out = 1'b0;
  assign tx_lk.out = q.tbit;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.car_s = {q.car_s[1:0], carrier_i};
    d.cts_s = {q.cts_s[1:0], cts_i};
    d.dsr_s = {q.dsr_s[1:0], dsr_i};
    d.rtg_s = {q.rtg_s[1:0], rx_lk.tog};
    d.ttg_s = {q.ttg_s[1:0], tx_lk.tog};
    d.car = smap_flt(q.car_s, q.car);
    d.cts = smap_flt(q.cts_s, q.cts);
    d.dsr = smap_flt(q.dsr_s, q.dsr);
    d.rtg = smap_flt(q.rtg_s, q.rtg);
    d.ttg = smap_flt(q.ttg_s, q.ttg);

    // Receive: the acknowledge clears first so any new set wins
    if (rx_acknowledge_i) begin
      if (q.rflag) begin
        d.rflag = 1'b0;
      end else begin
        d.rint = '0;
      end
    end
    if (rx_start_order_i) begin
      d.rbusy = 1'b1;
      d.rst = RX_HUNT;
      d.rcnt = '0;
      d.rpfe = 1'b0;
      d.rovr = 1'b0;
    end else if (rx_stop_order_i) begin
      d.rbusy = 1'b0;
      d.rst = RX_OFF;
    end else if (rx_ev) begin
      d.rsh = rx_char;
      d.rcnt = q.rcnt + ONE_BIT;
      unique case (q.rst)
        RX_HUNT: begin
          d.rcnt = '0;
          if (!sync_mode_i) begin
            if (rx_lk.dat == START_BIT) begin
              d.rst = RX_CHAR;
            end
          end else if (rx_char == SYNC_CHAR) begin
            d.rst = RX_SYNC2;
          end
        end
        RX_SYNC2: begin
          if (q.rcnt == BIT_LAST) begin
            d.rcnt = '0;
            d.rst = (rx_char == SYNC_CHAR) ? RX_CHAR : RX_HUNT;
          end
        end
        RX_CHAR, RX_STOP: begin
          if (rx_ovr) begin
            d.rovr = 1'b1;
            d.rst = RX_RATE;
            d.rint[IC_RATE] = 1'b1;
            d.rint[IC_ERR] = 1'b1;
          end else if (q.rst == RX_STOP) begin
            d.rst = RX_HUNT;
          end else if (rx_done) begin
            d.rflag = 1'b1;
            d.rdat = rx_byte;
            d.rcnt = '0;
            d.rst = sync_mode_i ? RX_CHAR : RX_STOP;
            if (rx_perr) begin
              d.rpfe = 1'b1;
              d.rint[IC_PARITY] = 1'b1;
              d.rint[IC_ERR] = 1'b1;
            end
          end
        end
        default: begin
          d.rcnt = q.rcnt;
        end
      endcase
    end
    if (q.rbusy && q.car && !d.car) begin
      d.rint[IC_NOCAR] = 1'b1;
    end
    d.rreq = d.rflag | (|d.rint);
    d.rstat = '0;
    d.rstat[ST_READY] = d.dsr & d.car & ~d.rbusy;
    d.rstat[ST_BUSY] = d.rbusy;
    d.rstat[ST_PARITY] = d.rpfe;
    d.rstat[ST_RATE] = d.rovr;

    // Transmit: an acknowledge serves a pending interrupt before data
    if (tx_ack_i && q.treqo) begin
      if (|q.tint) begin
        d.tint = '0;
      end else if (q.treq) begin
        d.tsh = sync_mode_i ? {MARK, MARK, tx_char}
                            : {MARK, tx_char, START_BIT};
        d.tcnt = sync_mode_i ? SYNC_CHAR_BITS : SS_CHAR_BITS;
        d.treq = 1'b0;
        d.tfirst = 1'b0;
        d.tst = TX_SEND;
      end
    end
    if (tx_ev) begin
      unique case (q.tst)
        TX_SEND: begin
          d.tbit = q.tsh[0];
          d.tsh = {MARK, q.tsh[9:1]};
          d.tcnt = q.tcnt - ONE_BIT;
          if (q.tcnt == ONE_BIT) begin
            d.tst = TX_REQ;
            d.treq = ~q.tstopd;
          end
        end
        TX_REQ: begin
          d.tbit = MARK;
          if (q.tstopd) begin
            d.tdly = q.tdly - ONE_BIT;
            if (q.tdly == ONE_BIT) begin
              d.tint[IC_EOREC] = 1'b1;
              d.tstopd = 1'b0;
              d.tbusy = 1'b0;
              d.rts = 1'b0;
              d.tst = TX_OFF;
            end
          end else if (!q.tfirst && d.tst == TX_REQ) begin
            d.tint[IC_EOREC] = 1'b1;
            d.tint[IC_ERR] = 1'b1;
          end
        end
        TX_FILL: begin
          d.tbit = idle_ones_i;
        end
        default: begin
          d.tbit = MARK;
        end
      endcase
    end
    if (q.tst == TX_RTS && q.cts) begin
      d.tst = TX_REQ;
      d.treq = 1'b1;
    end
    // Only these three orders exist on the transmit side
    if (tx_start_order_i) begin
      d.tbusy = 1'b1;
      d.tidle = 1'b0;
      d.tfirst = 1'b1;
      d.tstopd = 1'b0;
      // With idles running the modem is already cleared to send
      if (q.rts) begin
        d.tst = TX_REQ;
        d.treq = 1'b1;
      end else begin
        d.tst = TX_RTS;
        d.rts = 1'b1;
      end
    end else if (tx_stop_order_i) begin
      d.tstopd = 1'b1;
      d.treq = 1'b0;
      d.tdly = sync_mode_i ? SYNC_CHAR_BITS : SS_CHAR_BITS;
    end else if (tx_idle_order_i) begin
      d.tidle = 1'b1;
      d.tst = TX_FILL;
      d.treq = 1'b0;
      d.rts = 1'b1;
      d.tint[IC_EOREC] = 1'b1;
    end
    if (tx_rst) begin
      d.tst = TX_OFF;
      d.treq = 1'b0;
      d.tbusy = 1'b0;
      d.tidle = 1'b0;
      d.tstopd = 1'b0;
      d.rts = 1'b0;
    end
    d.treqo = d.treq | (|d.tint);
    d.tstat = '0;
    d.tstat[ST_READY] = d.dsr & ~d.tbusy;
    d.tstat[ST_BUSY] = d.tbusy;
    d.tstat[ST_IDLE] = d.tidle;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign rts_o = q.rts;
  assign rx_request_o = q.rreq;
  assign rx_data_o = q.rdat;
  assign rx_status_o = q.rstat;
  assign rx_interrupt_condition_bits_o = q.rint;
  assign tx_request_o = q.treqo;
  assign tx_status_o = q.tstat;
  assign tx_interrupt_condition_bits_o = q.tint;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_start;
    tx_start_order_i && !tx_rst && !q.rts;
  endsequence
  sequence s_rx_bad;
    rx_done && rx_perr;
  endsequence

  property p_tx_busy;
    tx_start_order_i && !tx_rst |=> q.tbusy && tx_status_o[ST_BUSY];
  endproperty
  a_tx_busy: assert property (p_tx_busy)
    else $error("start order did not set busy");
  property p_rts;
    s_tx_start |=> rts_o && q.tst == TX_RTS;
  endproperty
  a_rts: assert property (p_rts)
    else $error("start order did not raise request-to-send");
  property p_tx_reset;
    tx_rst |=> !q.treq && !q.tbusy && q.tst == TX_OFF;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("stop reset left transmit state");
  property p_idle;
    tx_idle_order_i && !tx_start_order_i && !tx_stop_order_i && !tx_rst
      |=> tx_status_o[ST_IDLE] && tx_interrupt_condition_bits_o[IC_EOREC];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle order did not flag status and end of record");
  property p_fill_line;
    tx_ev && q.tst == TX_FILL |=> q.tbit == $past(idle_ones_i);
  endproperty
  a_fill_line: assert property (p_fill_line)
    else $error("idle fill level wrong");
  property p_stop_delay;
    tx_stop_order_i && !tx_start_order_i && !tx_rst |=> q.tstopd && !q.treq;
  endproperty
  a_stop_delay: assert property (p_stop_delay)
    else $error("stop order did not arm the delay");
  property p_rx_parity;
    s_rx_bad |=> rx_status_o[ST_PARITY]
      && rx_interrupt_condition_bits_o[IC_ERR];
  endproperty
  a_rx_parity: assert property (p_rx_parity)
    else $error("parity error not flagged");
  property p_rx_sub;
    s_rx_bad ##0 par_sub80_i |=> rx_data_o == PAR_SUB_CHAR && rx_request_o;
  endproperty
  a_rx_sub: assert property (p_rx_sub)
    else $error("bad character not replaced");
  property p_overrun;
    rx_ovr |=> q.rst == RX_RATE && rx_status_o[ST_RATE]
      && rx_interrupt_condition_bits_o[IC_RATE];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not reported");
  property p_err_sum;
    $rose(q.rint[IC_RATE]) || $rose(q.rint[IC_PARITY]) |-> q.rint[IC_ERR];
  endproperty
  a_err_sum: assert property (p_err_sum)
    else $error("error summary missing");
  property p_carrier;
    q.rbusy && q.car && !d.car |=> rx_interrupt_condition_bits_o[IC_NOCAR];
  endproperty
  a_carrier: assert property (p_carrier)
    else $error("carrier loss not flagged");
  property p_rx_hold;
    q.rflag && !rx_acknowledge_i |=> q.rflag && rx_request_o
      && $stable(rx_data_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("character dropped before acknowledge");
  property p_rx_req;
    !q.rflag && (|q.rint) && !rx_acknowledge_i |=> rx_request_o;
  endproperty
  a_rx_req: assert property (p_rx_req)
    else $error("pending interrupt did not request");

endmodule : smap_adapter
`default_nettype wire

// file: test/smap_modem_model.sv
// Modem model: serial clocks, receive data, clear-to-send, line capture
`timescale 1ns/1ps
`default_nettype none
module smap_modem_model (
  // Base clock
  input wire logic lclk_i,
  // From the adapter
  input wire logic rts_i,
  input wire logic txd_i,
  // To the adapter
  output logic rx_serial_clock_o,
  output logic tx_serial_clock_o,
  output logic rxd_o,
  output logic cts_o
);
  // ==========================================================
  // Bit clocks, free running; slow enough for the core's sampling
  logic [4:0] div_q = 5'h00;
  logic bits_q[$];
  logic [63:0] hist_q = 64'h0;
  always @(posedge lclk_i) begin
    div_q <= div_q + 5'h01;
  end
  assign rx_serial_clock_o = div_q[4];
  assign tx_serial_clock_o = ~div_q[4];
  // ==========================================================
  // Receive data changes on the falling clock; line rests at mark
  initial rxd_o = 1'b1;
  always @(negedge rx_serial_clock_o) begin
    if (bits_q.size() != 0) rxd_o <= bits_q.pop_front();
    else rxd_o <= 1'b1;
  end
  // Clear-to-send lags request-to-send by up to one bit time
  initial cts_o = 1'b0;
  always @(posedge tx_serial_clock_o) begin
    cts_o <= rts_i;
  end
  // Line sampled half a bit after the adapter launches it
  always @(negedge tx_serial_clock_o) begin
    hist_q <= {hist_q[62:0], txd_i};
  end
  // Queue n bits, lowest first
  task automatic send(input logic [9:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      bits_q.push_back(b[i]);
    end
  endtask : send
endmodule : smap_modem_model
`default_nettype wire

// file: test/tb_sync_modem_adapter_parity.sv
// Self-checking bench of the synchronous modem adapter
`timescale 1ns/1ps
`default_nettype none
module tb_sync_modem_adapter_parity;
  import smap_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic carrier = 1'b1;
  logic sync_mode = 1'b1;
  logic par_en = 1'b0;
  logic par_odd = 1'b1;
  logic sub80 = 1'b0;
  logic idle_ones = 1'b1;
  logic treset = 1'b0;
  logic tx_en = 1'b1;
  logic rx_acknowledge = 1'b0;
  logic tack = 1'b0;
  logic [4:0] ord = 5'h00;
  logic [7:0] txd8 = 8'h00;
  logic rxc, txc, rxd, cts, rts, txd, rreq, treq;
  logic [7:0] rdat;
  logic [STAT_W-1:0] rsts, ric, tst, tic;
  logic [5:0] evt;
  int err_total = 0;
  int cmp_count = 0;
  assign evt = {ric[IC_NOCAR], ric[IC_RATE], tic[IC_ERR], tic[IC_EOREC],
                treq, rreq};
  initial begin
    forever #25 mclk = ~mclk;
  end
  initial begin
    forever #16 lclk = ~lclk;
  end
  smap_adapter dut (
    .mclk_i(mclk), .rst_i(rst), .rx_serial_clock_i(rxc),
    .tx_serial_clock_i(txc), .rxd_i(rxd), .carrier_i(carrier), .cts_i(cts),
    .dsr_i(1'b1), .rts_o(rts), .txd_o(txd), .sync_mode_i(sync_mode),
    .parity_en_i(par_en), .parity_odd_i(par_odd), .par_sub80_i(sub80),
    .idle_ones_i(idle_ones), .stop_reset_i(treset), .tx_enable_i(tx_en),
    .tx_start_order_i(ord[0]), .tx_stop_order_i(ord[1]),
    .tx_idle_order_i(ord[2]), .rx_start_order_i(ord[3]),
    .rx_stop_order_i(ord[4]), .rx_request_o(rreq),
    .rx_acknowledge_i(rx_acknowledge), .rx_data_o(rdat), .rx_status_o(rsts),
    .rx_interrupt_condition_bits_o(ric), .tx_request_o(treq),
    .tx_ack_i(tack), .tx_data_i(txd8), .tx_status_o(tst),
    .tx_interrupt_condition_bits_o(tic)
  );
  smap_modem_model modem (
    .lclk_i(lclk), .rts_i(rts), .txd_i(txd), .rx_serial_clock_o(rxc),
    .tx_serial_clock_o(txc), .rxd_o(rxd), .cts_o(cts)
  );
  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Waits for one of the event bits, never open-ended
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (n < 4000 && evt[w] !== 1'b1) begin
      tick(1);
      n++;
    end
    if (n == 4000) begin
      err_total++;
      $display("FAIL %0t no event %0d", $time, w);
      print_verdict();
    end
  endtask : wait_on
  task automatic order(input int k);
    @(posedge mclk);
    ord <= 5'h01 << k;
    @(posedge mclk);
    ord <= 5'h00;
    tick(1);
  endtask : order
  task automatic ack(input logic rx, input logic [7:0] d);
    @(posedge mclk);
    rx_acknowledge <= rx;
    tack <= ~rx;
    txd8 <= d;
    @(posedge mclk);
    rx_acknowledge <= 1'b0;
    tack <= 1'b0;
    tick(1);
  endtask : ack
  // Transmit reset, then the pending interrupt bits are acknowledged
  task automatic tx_clear();
    @(posedge mclk);
    treset <= 1'b1;
    @(posedge mclk);
    treset <= 1'b0;
    tick(2);
    chk({6'h0, tst[ST_BUSY], rts}, 8'h00, "tx reset");
    ack(1'b0, 8'h00);
    chk({1'b0, tic}, 8'h00, "tx icb left");
  endtask : tx_clear
  // ==========================================================
  // Scenarios
  task automatic sc_rx_sync(input logic [7:0] ch, input logic [7:0] exp,
                            input logic bad);
    order(3);
    chk({6'h0, rsts[ST_BUSY], rsts[ST_READY]}, 8'h02, "rx busy");
    modem.send(10'h016, 8);
    modem.send(10'h016, 8);
    modem.send({2'b00, ch}, 8);
    wait_on(0);
    chk(rdat, exp, "rx byte");
    chk({7'h0, rsts[ST_PARITY]}, {7'h0, bad}, "parity status");
    chk({1'b0, ric}, bad ? 8'h24 : 8'h00, "rx icb");
    ack(1'b1, 8'h00);
    chk({7'h0, rreq}, {7'h0, bad}, "icb request");
    if (bad) ack(1'b1, 8'h00);
    chk({7'h0, rreq}, 8'h00, "request dropped");
    order(4);
    chk({6'h0, rsts[ST_BUSY], rsts[ST_READY]}, 8'h01, "rx stopped");
  endtask : sc_rx_sync
  task automatic sc_rx_over();
    order(3);
    modem.send(10'h016, 8);
    modem.send(10'h016, 8);
    modem.send(10'h0aa, 8);
    modem.send(10'h0bb, 8);
    wait_on(4);
    chk({1'b0, ric}, 8'h30, "rate icb");
    chk({7'h0, rsts[ST_RATE]}, 8'h01, "overrun status");
    ack(1'b1, 8'h00);
    ack(1'b1, 8'h00);
    chk({1'b0, ric}, 8'h00, "rate icb cleared");
    order(4);
  endtask : sc_rx_over
  task automatic sc_carrier();
    order(3);
    @(posedge mclk);
    carrier <= 1'b0;
    wait_on(5);
    chk({1'b0, ric}, 8'h40, "carrier icb");
    @(posedge mclk);
    carrier <= 1'b1;
    ack(1'b1, 8'h00);
    chk({1'b0, ric}, 8'h00, "carrier cleared");
    order(4);
  endtask : sc_carrier
  task automatic sc_tx_frame();
    int i;
    int k;
    logic [9:0] fr;
    order(0);
    tick(1);
    chk({6'h0, tst[ST_BUSY], rts}, 8'h03, "busy and rts");
    @(posedge mclk);
    tx_en <= 1'b0;
    treset <= 1'b1;
    @(posedge mclk);
    tx_en <= 1'b1;
    treset <= 1'b0;
    tick(1);
    chk({6'h0, tst[ST_BUSY], rts}, 8'h03, "reset needs enable");
    wait_on(1);
    ack(1'b0, 8'h5a);
    order(1);
    wait_on(2);
    chk({6'h0, tst[ST_BUSY], rts}, 8'h00, "after stop");
    k = 0;
    for (i = 62; i > 9; i--) begin
      if (k == 0 && modem.hist_q[i+1] === 1'b1 && modem.hist_q[i] === 1'b0)
        k = i;
    end
    for (i = 0; i < 10; i++) begin
      fr[i] = modem.hist_q[k-i];
    end
    chk(fr[8:1], {~^7'h5a, 7'h5a}, "data and parity");
    chk({6'h0, fr[9], fr[0]}, 8'h02, "start and stop");
    tx_clear();
  endtask : sc_tx_frame
  task automatic sc_tx_over();
    order(0);
    wait_on(1);
    ack(1'b0, 8'h33);
    wait_on(3);
    chk({1'b0, tic}, 8'h28, "tx overrun");
    tx_clear();
  endtask : sc_tx_over
  task automatic sc_idle();
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      idle_ones <= v[0];
      order(2);
      wait_on(2);
      chk({1'b0, tst & 7'h20}, 8'h20, "idle status");
      // Long enough for eight fill bits to reach the capture register
      tick(400);
      chk(modem.hist_q[7:0], {8{v[0]}}, "idle level");
      tx_clear();
    end
  endtask : sc_idle
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk({rreq, tst | tic | rsts | ric}, 8'h00, "reset outputs");
    tick(4);
    chk({4'h0, rsts[1:0], tst[1:0]}, 8'h05, "ready status");
    sc_rx_sync(8'hd5, 8'hd5, 1'b0);
    @(posedge mclk);
    par_en <= 1'b1;
    sc_rx_sync(8'hc1, 8'h41, 1'b0);
    sc_rx_sync(8'h41, 8'hc1, 1'b1);
    @(posedge mclk);
    sub80 <= 1'b1;
    sc_rx_sync(8'h41, 8'h80, 1'b1);
    @(posedge mclk);
    sync_mode <= 1'b0;
    par_odd <= 1'b0;
    order(3);
    modem.send({1'b1, ^7'h35, 7'h35, 1'b0}, 10);
    wait_on(0);
    chk(rdat, 8'h35, "start-stop byte");
    ack(1'b1, 8'h00);
    order(4);
    @(posedge mclk);
    sync_mode <= 1'b1;
    par_en <= 1'b0;
    par_odd <= 1'b1;
    sc_rx_over();
    sc_carrier();
    @(posedge mclk);
    sync_mode <= 1'b0;
    sc_tx_frame();
    sc_tx_over();
    sc_idle();
    print_verdict();
  end
endmodule : tb_sync_modem_adapter_parity
`default_nettype wire
